// ===== design/vip_prioritizer.sv
// interrupt capture, priority encoding and vector address substitution
`default_nettype none

module vip_prioritizer (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic mode13_in,
    input wire logic phi1_in,
    input wire logic phi2_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] req_in,
    input wire logic [12:0] req13_n_in,
    output logic irq_n_out,
    output logic vec_detect_out,
    output logic freeze_out,
    output vip_pkg::vip_rom_bus_t rom_out
);
    import vip_pkg::*;

    // ----------------------------------------------------------------
    // eight-level table: 256 words of 4 bits
    // ----------------------------------------------------------------
    function automatic logic [3:0] lut8(input logic [7:0] idx);
        logic [3:0] code;
        code = VIP_CODE_NONE;
        for (int i = VIP_N8 - 1; i >= 0; i--) begin
            if (idx[i]) begin
                code = VIP_CODE8[i];
            end
        end
        return code;
    endfunction : lut8

    logic [3:0] code_rom [0:255];

    always_comb begin
        for (int k = 0; k < 256; k++) begin
            code_rom[k] = lut8(8'(k));
        end
    end

    // ----------------------------------------------------------------
    // phase edge detection
    // ----------------------------------------------------------------
    logic phi1_q_ff, phi2_q_ff;
    logic nxt_phi1_q, nxt_phi2_q;
    logic phi1_fall, phi2_fall, phi2_rise;

    always_comb begin
        nxt_phi1_q = phi1_in;
        nxt_phi2_q = phi2_in;
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            phi1_q_ff <= 1'b0;
            phi2_q_ff <= 1'b0;
        end else begin
            phi1_q_ff <= nxt_phi1_q;
            phi2_q_ff <= nxt_phi2_q;
        end
    end

    assign phi1_fall = phi1_q_ff & ~phi1_in;
    assign phi2_fall = phi2_q_ff & ~phi2_in;
    assign phi2_rise = ~phi2_q_ff & phi2_in;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic detect;
    logic detect8, detect13;

    assign detect8 = (addr_in[15:1] == VIP_VEC_ADDR[15:1]);
    assign detect13 = ~addr_in[1] & ~addr_in[2] & addr_in[3] & addr_in[VIP_A13];
    assign detect = mode13_in ? detect13 : detect8;

    // ----------------------------------------------------------------
    // capture register and freeze flip-flop
    // ----------------------------------------------------------------
    logic [12:0] cap_ff, nxt_cap;
    logic freeze_ff, nxt_freeze;
    logic [12:0] sample;

    always_comb begin
        if (mode13_in) begin
            sample = ~req13_n_in;
        end else begin
            sample = {5'h00, req_in};
        end
    end

    always_comb begin
        nxt_cap = cap_ff;
        nxt_freeze = freeze_ff;
        if (phi2_fall && !freeze_ff && !detect) begin
            nxt_cap = sample;
        end
        if (phi1_fall) begin
            nxt_freeze = detect;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            cap_ff <= VIP_CAP_RST;
            freeze_ff <= VIP_FREEZE_RST;
        end else begin
            cap_ff <= nxt_cap;
            freeze_ff <= nxt_freeze;
        end
    end

    // ----------------------------------------------------------------
    // thirteen-level cascade
    // ----------------------------------------------------------------
    logic [7:0] hi_d_n, lo_d_n;
    logic [2:0] hi_a_n, lo_a_n;
    logic hi_gs_n, lo_gs_n, hi_eo_n;
    logic [3:0] code13, code8, code;
    logic any13, any8, any_req;

    always_comb begin
        hi_d_n = 8'hFF;
        for (int i = 0; i < VIP_UPPER_USED; i++) begin
            hi_d_n[VIP_UPPER_USED - 1 - i] = ~cap_ff[i];
        end
        for (int i = 0; i < VIP_N8; i++) begin
            lo_d_n[i] = ~cap_ff[VIP_N13 - 1 - i];
        end
    end

    vip_prio_enc8 u_hi (
        .ei_n_in(1'b0),
        .d_n_in(hi_d_n),
        .a_n_out(hi_a_n),
        .gs_n_out(hi_gs_n),
        .eo_n_out(hi_eo_n)
    );

    vip_prio_enc8 u_lo (
        .ei_n_in(hi_eo_n),
        .d_n_in(lo_d_n),
        .a_n_out(lo_a_n),
        .gs_n_out(lo_gs_n),
        .eo_n_out()
    );

    assign code13 = {hi_eo_n, ~(hi_a_n & lo_a_n)};
    assign any13 = ~(hi_gs_n & lo_gs_n);
    assign code8 = code_rom[cap_ff[7:0]];
    assign any8 = |cap_ff[7:0];
    assign code = mode13_in ? code13 : code8;
    assign any_req = mode13_in ? any13 : any8;

    // ----------------------------------------------------------------
    // interrupt request, updated on phase-two rise
    // ----------------------------------------------------------------
    logic irq_n_ff, nxt_irq_n;

    always_comb begin
        nxt_irq_n = irq_n_ff;
        if (phi2_rise) begin
            nxt_irq_n = ~any_req;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            irq_n_ff <= VIP_IRQ_N_RST;
        end else begin
            irq_n_ff <= nxt_irq_n;
        end
    end

    // ----------------------------------------------------------------
    // rom address selector and chip enable
    // ----------------------------------------------------------------
    always_comb begin
        rom_out.addr = addr_in[VIP_ROM_AW - 1:0];
        if (detect) begin
            rom_out.addr[VIP_SUB_MSB:VIP_SUB_LSB] = code;
        end
        if (mode13_in) begin
            rom_out.ce = addr_in[VIP_A15] & addr_in[VIP_A14];
        end else begin
            rom_out.ce = (addr_in[15:VIP_ROM8_SEL_LSB] == VIP_ROM8_SEL);
        end
    end

    assign irq_n_out = irq_n_ff;
    assign vec_detect_out = detect;
    assign freeze_out = freeze_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_subst;
        @(posedge clk_in) disable iff (!resetn_in)
        detect |-> rom_out.addr[4:1] == code;
    endproperty
    a_subst: assert property (p_subst) else $error("substituted code missing");

    property p_pass;
        @(posedge clk_in) disable iff (!resetn_in)
        !mode13_in && addr_in[15:1] != 15'h7FFC |-> !detect && rom_out.addr[4:1] == addr_in[4:1];
    endproperty
    a_pass: assert property (p_pass) else $error("address not passed through");

    property p_load;
        @(posedge clk_in) disable iff (!resetn_in)
        phi2_fall && !freeze_ff && !detect |=> cap_ff == $past(sample);
    endproperty
    a_load: assert property (p_load) else $error("capture did not reload");

    property p_freeze_set;
        @(posedge clk_in) disable iff (!resetn_in)
        phi1_fall && detect |=> freeze_ff ##0 $stable(cap_ff);
    endproperty
    a_freeze_set: assert property (p_freeze_set) else $error("freeze not raised");

    property p_freeze_clr;
        @(posedge clk_in) disable iff (!resetn_in)
        phi1_fall && !detect |=> !freeze_ff;
    endproperty
    a_freeze_clr: assert property (p_freeze_clr) else $error("freeze not dropped");

    property p_irq_rise;
        @(posedge clk_in) disable iff (!resetn_in)
        phi2_rise |=> irq_n_out == !$past(any_req);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq wrong after phase-two rise");

    property p_irq_hold;
        @(posedge clk_in) disable iff (!resetn_in)
        !phi2_rise |=> $stable(irq_n_out);
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq moved off phase-two rise");

    property p_top8;
        @(posedge clk_in) disable iff (!resetn_in)
        !mode13_in && cap_ff[0] |-> code == 4'hC;
    endproperty
    a_top8: assert property (p_top8) else $error("request zero not highest");

    property p_low8;
        @(posedge clk_in) disable iff (!resetn_in)
        !mode13_in && cap_ff[7:0] == 8'h80 |-> code == 4'h5;
    endproperty
    a_low8: assert property (p_low8) else $error("lowest eight-level code wrong");

    property p_top13;
        @(posedge clk_in) disable iff (!resetn_in)
        mode13_in && any13 |-> code13 <= VIP_CODE13_TOP && code13[3] == |cap_ff[4:0];
    endproperty
    a_top13: assert property (p_top13) else $error("thirteen-level code out of range");

    property p_reset;
        @(posedge clk_in)
        !resetn_in |=> cap_ff == VIP_CAP_RST && !freeze_ff && irq_n_out;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");

    property p_freeze_hold;
        @(posedge clk_in) disable iff (!resetn_in)
        freeze_ff |=> $stable(cap_ff);
    endproperty
    a_freeze_hold: assert property (p_freeze_hold) else $error("capture moved while frozen");

    property p_detect_hold;
        @(posedge clk_in) disable iff (!resetn_in)
        detect |=> $stable(cap_ff);
    endproperty
    a_detect_hold: assert property (p_detect_hold) else $error("capture moved during vector fetch");

    property p_det13;
        @(posedge clk_in) disable iff (!resetn_in)
        mode13_in && addr_in[15:1] == 15'h7FFC |-> detect;
    endproperty
    a_det13: assert property (p_det13) else $error("thirteen-level fetch not detected");

    property p_ce13;
        @(posedge clk_in) disable iff (!resetn_in)
        mode13_in && addr_in[15:14] == 2'h3 |-> rom_out.ce;
    endproperty
    a_ce13: assert property (p_ce13) else $error("thirteen-level rom not enabled");

    property p_req0_13;
        @(posedge clk_in) disable iff (!resetn_in)
        mode13_in && cap_ff[0] |-> code == 4'hC;
    endproperty
    a_req0_13: assert property (p_req0_13) else $error("thirteen-level request zero not highest");

    property p_low13;
        @(posedge clk_in) disable iff (!resetn_in)
        mode13_in && cap_ff == 13'h1000 |-> code == 4'h0;
    endproperty
    a_low13: assert property (p_low13) else $error("thirteen-level lowest code wrong");

    property p_irq13;
        @(posedge clk_in) disable iff (!resetn_in)
        mode13_in && phi2_rise && (|cap_ff) |=> !irq_n_out;
    endproperty
    a_irq13: assert property (p_irq13) else $error("thirteen-level irq not raised");

    property p_unused_hi;
        @(posedge clk_in) disable iff (!resetn_in)
        mode13_in |-> hi_d_n[7:5] == 3'h7;
    endproperty
    a_unused_hi: assert property (p_unused_hi) else $error("reserved upper encoder inputs driven");

endmodule : vip_prioritizer

`default_nettype wire

// ===== design/vip_pkg.sv
// shared constants and types for the vectored interrupt prioritizer
`default_nettype none

package vip_pkg;

    // ----------------------------------------------------------------
    // address map
    // ----------------------------------------------------------------
    localparam logic [15:0] VIP_VEC_ADDR = 16'hFFF8;
    localparam int VIP_SUB_LSB = 1;
    localparam int VIP_SUB_MSB = 4;
    localparam int VIP_ROM_AW = 10;
    localparam logic [5:0] VIP_ROM8_SEL = 6'h3F;
    localparam int VIP_ROM8_SEL_LSB = 10;
    localparam int VIP_A13 = 13;
    localparam int VIP_A14 = 14;
    localparam int VIP_A15 = 15;

    // ----------------------------------------------------------------
    // request widths and codes
    // ----------------------------------------------------------------
    localparam int VIP_N8 = 8;
    localparam int VIP_N13 = 13;
    localparam int VIP_UPPER_USED = 5;
    localparam logic [3:0] VIP_CODE_NONE = 4'h0;
    localparam logic [3:0] VIP_CODE13_TOP = 4'hC;
    localparam logic [3:0] VIP_CODE8 [0:7] = '{4'hC, 4'hB, 4'hA, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5};

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [12:0] VIP_CAP_RST = 13'h0000;
    localparam logic VIP_FREEZE_RST = 1'b0;
    localparam logic VIP_IRQ_N_RST = 1'b1;

    typedef struct packed {
        logic ce;
        logic [9:0] addr;
    } vip_rom_bus_t;

endpackage : vip_pkg

`default_nettype wire

// ===== design/vip_prio_enc8.sv
// eight-input priority encoder, active-low, input seven highest
`default_nettype none

module vip_prio_enc8 (
    input wire logic ei_n_in,
    input wire logic [7:0] d_n_in,
    output logic [2:0] a_n_out,
    output logic gs_n_out,
    output logic eo_n_out
);
    import vip_pkg::*;

    always_comb begin
        a_n_out = 3'h7;
        gs_n_out = 1'b1;
        eo_n_out = 1'b1;
        if (!ei_n_in) begin
            // enable out low only when no input is active, to wake the next stage
            eo_n_out = ~(&d_n_in);
            gs_n_out = &d_n_in;
            for (int i = 0; i < 8; i++) begin
                if (!d_n_in[i]) begin
                    a_n_out = ~3'(i);
                end
            end
        end
    end

endmodule : vip_prio_enc8

`default_nettype wire

// ===== sim/vip_cpu_model.sv
// processor bus model: phase clocks and vector fetch addresses
`default_nettype none

module vip_cpu_model (
    input wire logic clk_in,
    input wire logic fetch_in,
    input wire logic [15:0] idle_addr_in,
    output logic phi1_out,
    output logic phi2_out,
    output logic [15:0] addr_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] cnt = 3'h0;
    logic [1:0] st = 2'h0;
    // non-overlapping phases, three clocks high each
    assign phi1_out = (cnt < 3'h3);
    assign phi2_out = (cnt > 3'h3) && (cnt != 3'h7);
    // vector fetch: one bus cycle on each byte of the pair
    assign addr_out = (st == 2'h1) ? 16'hFFF8 : (st == 2'h2) ? 16'hFFF9 : idle_addr_in;
    always @(negedge clk_in) begin
        cnt <= cnt + 3'h1;
        if (cnt == 3'h7) begin
            st <= (st == 2'h2) ? 2'h0 : ((st == 2'h1) || fetch_in) ? st + 2'h1 : st;
        end
    end
endmodule : vip_cpu_model

`default_nettype wire

// ===== sim/vip_prioritizer_tb.sv
// self-checking bench for the vectored interrupt prioritizer
`default_nettype none

module vip_prioritizer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import vip_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic mode13_in = 1'b0;
    logic fetch = 1'b0;
    logic [15:0] idle_addr = 16'h0000;
    logic [7:0] req_in = 8'h00;
    logic [12:0] req13_n_in = 13'h1FFF;
    logic phi1, phi2, irq_n, det, frz;
    logic [15:0] addr;
    vip_rom_bus_t rom;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    vip_cpu_model vip_cpu_model_i (.clk_in(clk_in), .fetch_in(fetch), .idle_addr_in(idle_addr),
        .phi1_out(phi1), .phi2_out(phi2), .addr_out(addr));
    vip_prioritizer vip_prioritizer_i (.clk_in(clk_in), .resetn_in(resetn_in), .mode13_in(mode13_in),
        .phi1_in(phi1), .phi2_in(phi2), .addr_in(addr), .req_in(req_in), .req13_n_in(req13_n_in),
        .irq_n_out(irq_n), .vec_detect_out(det), .freeze_out(frz), .rom_out(rom));

    // ----------------------------------------------------------------
    // clock, timeout, compare and report
    // ----------------------------------------------------------------
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_vec

    task automatic report_and_stop;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------------------------
    // shared sequences
    // ----------------------------------------------------------------
    task automatic wait_irq(input logic lvl);
        for (int k = 0; k < 40 && irq_n !== lvl; k++) @(negedge clk_in);
        chk_bit("irq_n", lvl, irq_n);
    endtask : wait_irq

    task automatic wait_addr(input logic [15:0] a);
        for (int k = 0; k < 40 && addr !== a; k++) @(posedge clk_in);
    endtask : wait_addr

    // late request lands while the vector is being read
    task automatic vec_fetch(input logic [3:0] code, input logic [7:0] late_req);
        fetch <= 1'b1;
        wait_addr(16'hFFF8);
        @(negedge clk_in);
        fetch <= 1'b0;
        req_in = late_req;
        repeat (5) @(negedge clk_in);
        chk_bit("detect", 1'b1, det);
        chk_vec("sub_code", {12'h000, code}, {12'h000, rom.addr[4:1]});
        chk_bit("freeze", 1'b1, frz);
        wait_addr(16'hFFF9);
        repeat (5) @(negedge clk_in);
        chk_vec("sub_code", {12'h000, code}, {12'h000, rom.addr[4:1]});
        wait_addr(idle_addr);
        repeat (8) @(negedge clk_in);
        chk_bit("freeze", 1'b0, frz);
    endtask : vec_fetch

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        @(negedge clk_in);
        req_in = 8'h10;
        wait_irq(1'b0);
        resetn_in = 1'b0;
        repeat (2) @(negedge clk_in);
        chk_bit("irq_n", 1'b1, irq_n);
        chk_bit("freeze", 1'b0, frz);
        req_in = 8'h00;
        resetn_in = 1'b1;
        @(negedge clk_in);
    endtask : t_reset

    task automatic t_levels8;
        for (int i = 0; i < 8; i++) begin
            req_in = 8'hFF << i;
            wait_irq(1'b0);
            vec_fetch(4'hC - i[3:0], req_in);
            req_in = 8'h00;
            wait_irq(1'b1);
        end
    endtask : t_levels8

    task automatic t_freeze;
        req_in = 8'h08;
        wait_irq(1'b0);
        vec_fetch(4'h9, 8'h01);
        vec_fetch(4'hC, 8'h00);
        wait_irq(1'b1);
    endtask : t_freeze

    task automatic t_decode;
        logic [15:0] a [6] = '{16'hFFFE, 16'hFBF8, 16'hFFFA, 16'h2008, 16'hC3F6, 16'hDFF8};
        for (int k = 0; k < 6; k++) begin
            @(negedge clk_in);
            mode13_in = (k > 2);
            idle_addr = a[k];
            @(posedge clk_in);
            chk_bit("detect", (k == 3), det);
            chk_bit("rom_ce", a[k][15] & a[k][14] & (mode13_in | (&a[k][13:10])), rom.ce);
            if (k != 3) chk_vec("rom_addr", {6'h00, a[k][9:0]}, {6'h00, rom.addr});
        end
        @(negedge clk_in);
    endtask : t_decode

    task automatic t_levels13;
        for (int i = 0; i < 13; i++) begin
            req13_n_in = ~(13'h1FFF << i);
            wait_irq(1'b0);
            vec_fetch(4'hC - i[3:0], 8'h00);
            req13_n_in = 13'h1FFF;
            wait_irq(1'b1);
        end
    endtask : t_levels13

    initial begin
        repeat (3) @(negedge clk_in);
        chk_bit("irq_n", 1'b1, irq_n);
        resetn_in = 1'b1;
        t_reset();
        t_levels8();
        t_freeze();
        t_decode();
        t_levels13();
        report_and_stop();
    end
endmodule : vip_prioritizer_tb

`default_nettype wire
